/* File: evsl_pkg.sv */
// Purpose: shared constants for the event status latch block
// Assumes: 32-bit AHB-Lite data, one register per aligned word
// Notes:   register indices are word indices; byte address is four times the index
package evsl_pkg;

  // bus widths
  localparam int unsigned EVSL_DATA_W = 32;
  localparam int unsigned EVSL_REG_W  = 16;
  localparam int unsigned EVSL_IDX_W  = 10;
  localparam int unsigned EVSL_IRQ_W  = 2;

  // register word indices (byte address = index * 4)
  localparam logic [9:0] EVSL_IDX_STATUS_ONE = 10'h019;
  localparam logic [9:0] EVSL_IDX_STATUS_TWO = 10'h01a;
  localparam logic [9:0] EVSL_IDX_IRQ_STATUS = 10'h040;
  localparam logic [9:0] EVSL_IDX_IRQ_CLEAR  = 10'h041;
  localparam logic [9:0] EVSL_IDX_IRQ_ENABLE = 10'h042;

  // event_status_one bit positions
  localparam int unsigned EVSL_B_CELL_OVERTEMP    = 15;
  localparam int unsigned EVSL_B_CELL_UNDERTEMP   = 14;
  localparam int unsigned EVSL_B_CELL_FAILURE     = 13;
  localparam int unsigned EVSL_B_CHARGE_TIMEOUT   = 12;
  localparam int unsigned EVSL_B_CHARGE_FINAL     = 11;
  localparam int unsigned EVSL_B_CHARGE_STARTED   = 10;
  localparam int unsigned EVSL_B_FAST_READY       = 9;
  localparam int unsigned EVSL_B_CLOCK_PERIODIC   = 7;
  localparam int unsigned EVSL_B_CLOCK_SECOND     = 6;
  localparam int unsigned EVSL_B_CLOCK_ALARM      = 5;
  localparam int unsigned EVSL_B_CELL_BELOW_HIGH  = 2;
  localparam int unsigned EVSL_B_CELL_BELOW_MID   = 1;
  localparam int unsigned EVSL_B_CELL_BELOW_LOW   = 0;

  // event_status_two bit positions
  localparam int unsigned EVSL_B_SINK_ONE         = 13;
  localparam int unsigned EVSL_B_SINK_TWO         = 12;
  localparam int unsigned EVSL_B_BUS_POWER_LIMIT  = 10;
  localparam int unsigned EVSL_B_AUX_DONE         = 8;
  localparam int unsigned EVSL_B_COMPARATOR_FOUR  = 7;
  localparam int unsigned EVSL_B_COMPARATOR_THREE = 6;
  localparam int unsigned EVSL_B_COMPARATOR_TWO   = 5;
  localparam int unsigned EVSL_B_COMPARATOR_ONE   = 4;
  localparam int unsigned EVSL_B_SUPPLY_SHUTDOWN  = 3;
  localparam int unsigned EVSL_B_DIE_WARM         = 2;
  localparam int unsigned EVSL_B_DIE_HOT          = 1;
  localparam int unsigned EVSL_B_WATCHDOG         = 0;

  // defined bits of each status register; the rest read as zero
  localparam logic [15:0] EVSL_MASK_ONE = 16'hfee7;
  localparam logic [15:0] EVSL_MASK_TWO = 16'h35ff;
  localparam logic [15:0] EVSL_FLAGS_RST = 16'h0000;

  // interrupt summary bits
  localparam int unsigned EVSL_IRQ_B_ONE = 0;
  localparam int unsigned EVSL_IRQ_B_TWO = 1;
  localparam logic [1:0]  EVSL_IRQ_RST   = 2'h0;

  // AHB-Lite encodings
  localparam logic [1:0]  EVSL_HTRANS_NONSEQ = 2'h2;
  localparam logic        EVSL_HRESP_OKAY    = 1'h0;
  localparam logic [31:0] EVSL_RDATA_RST     = 32'h0000_0000;

  // word index match, used by every read decode; the data phase write decode compares wr_idx directly
  function automatic logic evsl_hit(input logic [31:0] addr, input logic [9:0] idx);
    evsl_hit = (addr[11:2] == idx);
  endfunction

endpackage

/* File: evsl_flag_latch.sv */
// Purpose: bank of sixteen rising-edge event flags with read-clear
// Assumes: sources are levels synchronous to hclk
// Notes:   a rise in the clearing cycle wins over the clear
module evsl_flag_latch #(
  parameter logic [15:0] MASK = 16'hffff
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // source levels and clear strobes
  input  wire logic [15:0] src,
  input  wire logic [15:0] clr,
  // latched flags and this cycle's rises
  output logic      [15:0] flags,
  output logic      [15:0] rise
);

  logic [15:0] prev;
  logic [15:0] next_prev;
  logic [15:0] next_flags;

  // edge detect; a held level never re-arms after a clear
  always_comb begin
    rise       = src & ~prev & MASK;
    next_prev  = src;
    next_flags = (flags & ~clr) | rise;
  end

  // state registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev  <= evsl_pkg::EVSL_FLAGS_RST;  // idle sources are low, so no false rise at release
      flags <= evsl_pkg::EVSL_FLAGS_RST;
    end else begin
      prev  <= next_prev;
      flags <= next_flags;
    end
  end

  AST_SET_BEATS_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
    (|(rise & clr)) |=> ((flags & $past(rise & clr)) == $past(rise & clr)))
    else $error("rise in the clearing cycle was lost");

  AST_UNDEFINED_STAY_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
    (flags & ~MASK) == 16'h0000)
    else $error("undefined flag position became set");

endmodule // evsl_flag_latch

/* File: evsl_irq_ctrl.sv */
// Purpose: sticky interrupt status, enable and write-one-to-clear
// Assumes: clear and enable writes arrive as one-cycle strobes
// Notes:   irq follows the next state so it lines up with status
module evsl_irq_ctrl (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // events and software writes
  input  wire logic [1:0] event_in,
  input  wire logic       clear_wr,
  input  wire logic       enable_wr,
  input  wire logic [1:0] wdata,
  // state
  output logic      [1:0] status,
  output logic      [1:0] enable,
  output logic            irq
);

  logic [1:0] next_status;
  logic [1:0] next_enable;
  logic       next_irq;

  // set wins over a simultaneous clear so no event is dropped
  always_comb begin
    next_status = (status & ~(clear_wr ? wdata : 2'h0)) | event_in;
    next_enable = enable_wr ? wdata : enable;
    next_irq    = |(next_status & next_enable);
  end

  // state registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status <= evsl_pkg::EVSL_IRQ_RST;
      enable <= evsl_pkg::EVSL_IRQ_RST;
      irq    <= 1'b0;
    end else begin
      status <= next_status;
      enable <= next_enable;
      irq    <= next_irq;
    end
  end

endmodule // evsl_irq_ctrl

/* File: evsl_event_latches.sv */
// Purpose: second-level event status latches behind an AHB-Lite slave
// Assumes: event sources are levels synchronous to hclk; word accesses only
// Notes:   zero-wait slave; read data comes from a register loaded at the
//          address phase, and the read-clear lands on that same edge
// Notes on behaviour
// - a flag sets only on a rising source edge; held levels do not re-set
// - reading a status register returns its flags, then clears them
// - status one bit 15 cell overtemp, bit 14 cell undertemp
// - status one bits 13..9: failure, timeout, final stage, started, fast ready
// - status one bit 7 periodic, bit 6 second tick, bit 5 alarm
// - status one bits 2,1,0: cell below high, mid and low thresholds
// - status two bits 13 and 12: sink one and two lost regulation
// - status two bit 10: bus power limit switch event
// - status two bit 8: auxiliary conversion complete
// - status two bits 7..4: comparators four down to one
// - status two bit 3: supply below shutdown threshold
// - status two bit 2 die warm limit, bit 1 die hot limit
// - status two bit 0: watchdog expired
module evsl_event_latches (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // interrupt
  output logic             irq,
  // charger and cell sources
  input  wire logic        cell_overtemp_src,
  input  wire logic        cell_undertemp_src,
  input  wire logic        cell_failure_src,
  input  wire logic        charge_timeout_src,
  input  wire logic        charge_final_stage_src,
  input  wire logic        charge_started_src,
  input  wire logic        fast_charge_ready_src,
  input  wire logic        cell_below_high_threshold_src,
  input  wire logic        cell_below_mid_threshold_src,
  input  wire logic        cell_below_low_threshold_src,
  // real-time clock sources
  input  wire logic        clock_periodic_src,
  input  wire logic        clock_second_tick_src,
  input  wire logic        clock_alarm_src,
  // sink, switch and converter sources
  input  wire logic        sink_one_regulation_src,
  input  wire logic        sink_two_regulation_src,
  input  wire logic        bus_power_limit_src,
  input  wire logic        aux_conversion_done_src,
  input  wire logic        comparator_four_src,
  input  wire logic        comparator_three_src,
  input  wire logic        comparator_two_src,
  input  wire logic        comparator_one_src,
  // system sources
  input  wire logic        supply_shutdown_threshold_src,
  input  wire logic        die_warm_limit_src,
  input  wire logic        die_hot_limit_src,
  input  wire logic        watchdog_expired_src
);

  logic [15:0] src_one;
  logic [15:0] src_two;
  logic [15:0] flags_one;
  logic [15:0] flags_two;
  logic [15:0] rise_one;
  logic [15:0] rise_two;
  logic [15:0] clr_one;
  logic [15:0] clr_two;
  logic        rd_take;
  logic        wr_take;
  logic        rd_one;
  logic        rd_two;
  logic        wr_pend;
  logic [9:0]  wr_idx;
  logic        next_wr_pend;
  logic [9:0]  next_wr_idx;
  logic [31:0] next_hrdata;
  logic        clear_wr;
  logic        enable_wr;
  logic [1:0]  irq_event;
  logic [1:0]  irq_status;
  logic [1:0]  irq_enable;

  // place each source at its documented position
  always_comb begin
    src_one = 16'h0000;
    src_two = 16'h0000;
    src_one[evsl_pkg::EVSL_B_CELL_OVERTEMP]    = cell_overtemp_src;
    src_one[evsl_pkg::EVSL_B_CELL_UNDERTEMP]   = cell_undertemp_src;
    src_one[evsl_pkg::EVSL_B_CELL_FAILURE]     = cell_failure_src;
    src_one[evsl_pkg::EVSL_B_CHARGE_TIMEOUT]   = charge_timeout_src;
    src_one[evsl_pkg::EVSL_B_CHARGE_FINAL]     = charge_final_stage_src;
    src_one[evsl_pkg::EVSL_B_CHARGE_STARTED]   = charge_started_src;
    src_one[evsl_pkg::EVSL_B_FAST_READY]       = fast_charge_ready_src;
    src_one[evsl_pkg::EVSL_B_CLOCK_PERIODIC]   = clock_periodic_src;
    src_one[evsl_pkg::EVSL_B_CLOCK_SECOND]     = clock_second_tick_src;
    src_one[evsl_pkg::EVSL_B_CLOCK_ALARM]      = clock_alarm_src;
    src_one[evsl_pkg::EVSL_B_CELL_BELOW_HIGH]  = cell_below_high_threshold_src;
    src_one[evsl_pkg::EVSL_B_CELL_BELOW_MID]   = cell_below_mid_threshold_src;
    src_one[evsl_pkg::EVSL_B_CELL_BELOW_LOW]   = cell_below_low_threshold_src;
    src_two[evsl_pkg::EVSL_B_SINK_ONE]         = sink_one_regulation_src;
    src_two[evsl_pkg::EVSL_B_SINK_TWO]         = sink_two_regulation_src;
    src_two[evsl_pkg::EVSL_B_BUS_POWER_LIMIT]  = bus_power_limit_src;
    src_two[evsl_pkg::EVSL_B_AUX_DONE]         = aux_conversion_done_src;
    src_two[evsl_pkg::EVSL_B_COMPARATOR_FOUR]  = comparator_four_src;
    src_two[evsl_pkg::EVSL_B_COMPARATOR_THREE] = comparator_three_src;
    src_two[evsl_pkg::EVSL_B_COMPARATOR_TWO]   = comparator_two_src;
    src_two[evsl_pkg::EVSL_B_COMPARATOR_ONE]   = comparator_one_src;
    src_two[evsl_pkg::EVSL_B_SUPPLY_SHUTDOWN]  = supply_shutdown_threshold_src;
    src_two[evsl_pkg::EVSL_B_DIE_WARM]         = die_warm_limit_src;
    src_two[evsl_pkg::EVSL_B_DIE_HOT]          = die_hot_limit_src;
    src_two[evsl_pkg::EVSL_B_WATCHDOG]         = watchdog_expired_src;
  end

  // address phase decode; hsize is not checked, only words are expected
  always_comb begin
    rd_take = hsel && hready && (htrans == evsl_pkg::EVSL_HTRANS_NONSEQ) && !hwrite;
    wr_take = hsel && hready && (htrans == evsl_pkg::EVSL_HTRANS_NONSEQ) && hwrite;
    rd_one  = rd_take && evsl_pkg::evsl_hit(haddr, evsl_pkg::EVSL_IDX_STATUS_ONE);
    rd_two  = rd_take && evsl_pkg::evsl_hit(haddr, evsl_pkg::EVSL_IDX_STATUS_TWO);
    clr_one = rd_one ? evsl_pkg::EVSL_MASK_ONE : 16'h0000;
    clr_two = rd_two ? evsl_pkg::EVSL_MASK_TWO : 16'h0000;
  end

  // the two flag banks
  evsl_flag_latch #(
    .MASK (evsl_pkg::EVSL_MASK_ONE)
  ) u_bank_one (
    .hclk    (hclk),
    .hresetn (hresetn),
    .src     (src_one),
    .clr     (clr_one),
    .flags   (flags_one),
    .rise    (rise_one)
  );

  evsl_flag_latch #(
    .MASK (evsl_pkg::EVSL_MASK_TWO)
  ) u_bank_two (
    .hclk    (hclk),
    .hresetn (hresetn),
    .src     (src_two),
    .clr     (clr_two),
    .flags   (flags_two),
    .rise    (rise_two)
  );

  // read data is sampled from the flags before the clear takes effect
  always_comb begin
    next_hrdata  = hrdata;
    next_wr_pend = wr_take;
    next_wr_idx  = wr_take ? haddr[11:2] : wr_idx;
    if (rd_take) begin
      next_hrdata = evsl_pkg::EVSL_RDATA_RST;
      if (rd_one) begin
        next_hrdata = {16'h0000, flags_one};
      end else if (rd_two) begin
        next_hrdata = {16'h0000, flags_two};
      end else if (evsl_pkg::evsl_hit(haddr, evsl_pkg::EVSL_IDX_IRQ_STATUS)) begin
        next_hrdata = {30'h0000_0000, irq_status};
      end else if (evsl_pkg::evsl_hit(haddr, evsl_pkg::EVSL_IDX_IRQ_ENABLE)) begin
        next_hrdata = {30'h0000_0000, irq_enable};
      end
    end
  end

  // bus state; never stalls and always answers OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= evsl_pkg::EVSL_RDATA_RST;
      hreadyout <= 1'b1;
      hresp     <= evsl_pkg::EVSL_HRESP_OKAY;
      wr_pend   <= 1'b0;
      wr_idx    <= 10'h000;
    end else begin
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= evsl_pkg::EVSL_HRESP_OKAY;
      wr_pend   <= next_wr_pend;
      wr_idx    <= next_wr_idx;
    end
  end

  // data phase writes; status registers are not write targets at all
  always_comb begin
    clear_wr  = wr_pend && (wr_idx == evsl_pkg::EVSL_IDX_IRQ_CLEAR);
    enable_wr = wr_pend && (wr_idx == evsl_pkg::EVSL_IDX_IRQ_ENABLE);
    irq_event = 2'h0;
    irq_event[evsl_pkg::EVSL_IRQ_B_ONE] = |rise_one;
    irq_event[evsl_pkg::EVSL_IRQ_B_TWO] = |rise_two;
  end

  // summary interrupt, one bit per status register
  evsl_irq_ctrl u_irq (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .event_in  (irq_event),
    .clear_wr  (clear_wr),
    .enable_wr (enable_wr),
    .wdata     (hwdata[1:0]),
    .status    (irq_status),
    .enable    (irq_enable),
    .irq       (irq)
  );

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence seq_read_one;
    rd_one && !(|rise_one);
  endsequence

  sequence seq_read_two;
    rd_two && !(|rise_two);
  endsequence

  AST_HELD_LEVEL_NO_RESET: assert property (
    (watchdog_expired_src && $past(watchdog_expired_src) && !flags_two[0]) |=> !flags_two[0])
    else $error("held watchdog level set its flag again");

  AST_READ_ONE_RETURN_CLEAR: assert property (
    seq_read_one |=> (hrdata[15:0] == $past(flags_one)) && (flags_one == 16'h0000))
    else $error("status one read did not return then clear");

  AST_READ_TWO_RETURN_CLEAR: assert property (
    seq_read_two |=> (hrdata[15:0] == $past(flags_two)) && (flags_two == 16'h0000))
    else $error("status two read did not return then clear");

  AST_OVERTEMP_BIT: assert property (
    $rose(cell_overtemp_src) |=> flags_one[15])
    else $error("cell overtemp not latched at bit 15");

  AST_TIMEOUT_BIT: assert property (
    $rose(charge_timeout_src) |=> flags_one[12])
    else $error("charge timeout not latched at bit 12");

  AST_ALARM_BIT: assert property (
    $rose(clock_alarm_src) |=> flags_one[5])
    else $error("clock alarm not latched at bit 5");

  AST_CELL_LOW_BIT: assert property (
    $rose(cell_below_low_threshold_src) |=> flags_one[0])
    else $error("low threshold not latched at bit 0");

  AST_SINK_TWO_BIT: assert property (
    $rose(sink_two_regulation_src) |=> flags_two[12])
    else $error("sink two not latched at bit 12");

  AST_BUS_LIMIT_BIT: assert property (
    $rose(bus_power_limit_src) |=> flags_two[10])
    else $error("bus power limit not latched at bit 10");

  AST_AUX_DONE_BIT: assert property (
    $rose(aux_conversion_done_src) |=> flags_two[8])
    else $error("conversion done not latched at bit 8");

  AST_COMPARATOR_FOUR_BIT: assert property (
    $rose(comparator_four_src) |=> flags_two[7])
    else $error("comparator four not latched at bit 7");

  AST_SUPPLY_BIT: assert property (
    $rose(supply_shutdown_threshold_src) |=> flags_two[3])
    else $error("supply shutdown not latched at bit 3");

  AST_DIE_HOT_BIT: assert property (
    $rose(die_hot_limit_src) |=> flags_two[1])
    else $error("die hot limit not latched at bit 1");

  AST_WATCHDOG_BIT: assert property (
    $rose(watchdog_expired_src) |=> flags_two[0])
    else $error("watchdog not latched at bit 0");

  AST_RESERVED_READ_ZERO: assert property (
    rd_one |=> (hrdata & ~{16'h0000, evsl_pkg::EVSL_MASK_ONE}) == 32'h0000_0000)
    else $error("undefined status bits read nonzero");

  AST_STATUS_WRITE_IGNORED: assert property (
    (wr_take && evsl_pkg::evsl_hit(haddr, evsl_pkg::EVSL_IDX_STATUS_ONE) && !(|rise_one))
      |=> ##1 ((flags_one & ~$past(flags_one, 2)) == 16'h0000) || $past(|rise_one))
    else $error("write changed status one");

  AST_RISE_DURING_READ: assert property (
    (rd_two && rise_two[evsl_pkg::EVSL_B_WATCHDOG]) |=> flags_two[evsl_pkg::EVSL_B_WATCHDOG]
      && (hrdata[evsl_pkg::EVSL_B_WATCHDOG] == $past(flags_two[evsl_pkg::EVSL_B_WATCHDOG])))
    else $error("rise during clearing read was lost");

endmodule // evsl_event_latches

/* File: evsl_host_model.sv */
// Purpose: host processor model reaching the status latches over AHB-Lite
// Assumes: single word transfers; the slave answers OKAY
// Notes:   waits on hready with no assumed latency; the bench bounds every wait
module evsl_host_model (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // bus answer
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // bus request
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus from time zero so nothing is taken during reset
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // one transfer: hold the address phase until hready, then the data phase likewise
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= addr;
    htrans <= evsl_pkg::EVSL_HTRANS_NONSEQ;
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    if (wr) begin
      hwdata <= wd;
    end
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

endmodule // evsl_host_model

/* File: evsl_event_latches_tb.sv */
// Purpose: self-checking bench for the event status latches
// Assumes: host model drives the bus; the bench drives the event sources
// Notes:   status byte addresses are four times the register index
module evsl_event_latches_tb;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [31:0] A_ONE = 32'h0000_0064;
  localparam logic [31:0] A_TWO = 32'h0000_0068;
  localparam logic [31:0] A_IST = 32'h0000_0100;
  localparam logic [31:0] A_ICL = 32'h0000_0104;
  localparam logic [31:0] A_IEN = 32'h0000_0108;

  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  logic [15:0] s1;
  logic [15:0] s2;
  int          bad_count;
  int          samples_checked;
  int          cycles = 0;

  // clock at 200 MHz
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  evsl_host_model evsl_host_model_i (
    .hclk(hclk), .hresetn(hresetn), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  // sources wired bit for bit to their status positions
  evsl_event_latches evsl_event_latches_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
    .cell_overtemp_src(s1[15]), .cell_undertemp_src(s1[14]), .cell_failure_src(s1[13]),
    .charge_timeout_src(s1[12]), .charge_final_stage_src(s1[11]),
    .charge_started_src(s1[10]), .fast_charge_ready_src(s1[9]),
    .clock_periodic_src(s1[7]), .clock_second_tick_src(s1[6]), .clock_alarm_src(s1[5]),
    .cell_below_high_threshold_src(s1[2]), .cell_below_mid_threshold_src(s1[1]),
    .cell_below_low_threshold_src(s1[0]), .sink_one_regulation_src(s2[13]),
    .sink_two_regulation_src(s2[12]), .bus_power_limit_src(s2[10]),
    .aux_conversion_done_src(s2[8]), .comparator_four_src(s2[7]),
    .comparator_three_src(s2[6]), .comparator_two_src(s2[5]),
    .comparator_one_src(s2[4]), .supply_shutdown_threshold_src(s2[3]),
    .die_warm_limit_src(s2[2]), .die_hot_limit_src(s2[1]), .watchdog_expired_src(s2[0]));

  // verdict and end of run, reached from the main sequence or the watchdog
  task automatic end_sim();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // single compare for every word result
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // change one source level, then let the edge detector see it
  task automatic drive(input logic sel, input int b, input logic v);
    @(posedge hclk);
    if (sel) begin
      s2[b] <= v;
    end else begin
      s1[b] <= v;
    end
    repeat (2) @(posedge hclk);
  endtask

  task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp);
    logic [31:0] rd;
    evsl_host_model_i.xfer(1'b0, addr, 32'h0, rd);
    chk(rd, exp);
  endtask

  task automatic wr(input logic [31:0] addr, input logic [31:0] wd);
    logic [31:0] rd;
    evsl_host_model_i.xfer(1'b1, addr, wd, rd);
  endtask

  // irq is registered, so look two edges on, past the launching edge
  task automatic irq_chk(input logic exp);
    repeat (2) @(posedge hclk);
    #1;
    chk({31'h0, irq}, {31'h0, exp});
  endtask

  // status and enable read zero out of reset, bus ready and OKAY, irq low
  task automatic t_reset();
    rd_chk(A_ONE, 32'h0);
    rd_chk(A_TWO, 32'h0);
    rd_chk(A_IEN, 32'h0);
    chk({30'h0, hreadyout, hresp}, 32'h2);
    irq_chk(1'b0);
  endtask

  // each defined bit in turn: rise, read once, read again while still held
  task automatic t_walk(input logic sel);
    logic [31:0] addr;
    logic [15:0] mask;
    addr = sel ? A_TWO : A_ONE;
    mask = sel ? evsl_pkg::EVSL_MASK_TWO : evsl_pkg::EVSL_MASK_ONE;
    for (int b = 0; b < 16; b++) begin
      if (mask[b]) begin
        drive(sel, b, 1'b1);
        rd_chk(addr, 32'h1 << b);
        rd_chk(addr, 32'h0);
        drive(sel, b, 1'b0);
        rd_chk(addr, 32'h0);
      end
    end
  endtask

  // writes to status and unmapped places change nothing
  task automatic t_writes();
    drive(1'b1, 3, 1'b1);
    wr(A_TWO, 32'h0);
    wr(A_ONE, 32'hffff_ffff);
    wr(32'h0000_0200, 32'hffff_ffff);
    rd_chk(A_ONE, 32'h0);
    rd_chk(A_TWO, 32'h8);
    rd_chk(32'h0000_0200, 32'h0);
    drive(1'b1, 3, 1'b0);
  endtask

  // a new rise landing on the clearing read's edge must survive it
  task automatic t_race();
    logic [31:0] rd;
    drive(1'b1, 0, 1'b1);
    drive(1'b1, 0, 1'b0);
    fork
      evsl_host_model_i.xfer(1'b0, A_TWO, 32'h0, rd);
      begin
        @(posedge hclk);
        s2[0] <= 1'b1;
      end
    join
    chk(rd, 32'h1);
    rd_chk(A_TWO, 32'h1);
    rd_chk(A_TWO, 32'h0);
    drive(1'b1, 0, 1'b0);
  endtask

  // summary interrupt: masked, enabled, cleared
  task automatic t_irq();
    wr(A_ICL, 32'h3);
    irq_chk(1'b0);
    wr(A_IEN, 32'h2);
    rd_chk(A_IEN, 32'h2);
    drive(1'b0, 15, 1'b1);
    irq_chk(1'b0);
    rd_chk(A_IST, 32'h1);
    drive(1'b1, 13, 1'b1);
    irq_chk(1'b1);
    rd_chk(A_IST, 32'h3);
    wr(A_ICL, 32'h2);
    irq_chk(1'b0);
    rd_chk(A_IST, 32'h1);
    rd_chk(A_ICL, 32'h0);
    rd_chk(A_ONE, 32'h8000);
    rd_chk(A_TWO, 32'h2000);
  endtask

  // watchdog on the whole run; the tests need under five hundred cycles
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      end_sim();
    end
  end

  // main sequence
  initial begin
    hresetn         = 1'b0;
    s1              = 16'h0000;
    s2              = 16'h0000;
    bad_count       = 0;
    samples_checked = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_walk(1'b0);
    t_walk(1'b1);
    t_writes();
    t_race();
    t_irq();
    end_sim();
  end

endmodule // evsl_event_latches_tb
